// file: rtl/fieldbus_status_pkg.sv
/*
 * shared constants and carriers for the cyclic status encoder:
 * register map, status codes, diagnostic flag bits, slot layout.
 * assumes a single 200 MHz clock domain and avalon-mm register access.
 */
package fieldbus_status_pkg;

    localparam int unsigned ADDR_W     = 5;
    localparam int unsigned SLOT_COUNT = 4;
    localparam int unsigned REC_BYTES  = 5;

    // register byte offsets
    localparam logic [4:0] REG_ADDR    = 5'h00;
    localparam logic [4:0] REG_SLOTCFG = 5'h04;
    localparam logic [4:0] REG_SIM     = 5'h08;
    localparam logic [4:0] REG_SIMVAL  = 5'h0C;
    localparam logic [4:0] REG_STATUS  = 5'h10;
    localparam logic [4:0] REG_OFFSET  = 5'h14;
    localparam logic [4:0] REG_DIAG    = 5'h18;
    localparam logic [4:0] REG_UNITS   = 5'h1C;

    // station address
    localparam logic [6:0] STATION_MAX   = 7'h7E;
    localparam logic [6:0] STATION_RESET = 7'h7E;
    localparam int unsigned ACTIVE_LSB   = 8;

    // module form per slot, two bits each
    localparam logic [1:0] FORM_EMPTY  = 2'h0;
    localparam logic [1:0] FORM_NORMAL = 2'h1;
    localparam logic [1:0] FORM_SHORT  = 2'h2;
    localparam logic [7:0] SLOTCFG_RESET = 8'h55;

    // status byte codes
    localparam logic [7:0] ST_GOOD      = 8'h80;
    localparam logic [7:0] ST_INIT      = 8'h4C;
    localparam logic [7:0] ST_LAST_USE  = 8'h44;
    localparam logic [7:0] ST_FAILSAFE  = 8'h10;
    localparam logic [7:0] ST_CFG_ERR   = 8'h04;
    localparam logic [7:0] ST_BAD_CFG   = 8'hC4;
    localparam logic [7:0] ST_FB_OOS    = 8'h1E;
    localparam logic [7:0] ST_AI_OOS    = 8'hDE;
    localparam logic [7:0] ST_SIM       = 8'h60;
    localparam logic [7:0] ST_HI_ALARM  = 8'h8E;
    localparam logic [7:0] ST_HI_WARN   = 8'h8A;
    localparam logic [7:0] ST_LO_ALARM  = 8'h8D;
    localparam logic [7:0] ST_LO_WARN   = 8'h89;
    localparam logic [7:0] OFFSET_NONE  = 8'hFF;

    // diagnostic flag word bit positions
    localparam int unsigned DG_ZERO      = 16;
    localparam int unsigned DG_POWER     = 17;
    localparam int unsigned DG_CFG       = 18;
    localparam int unsigned DG_WARM      = 19;
    localparam int unsigned DG_COLD      = 20;
    localparam int unsigned DG_ELEC      = 24;
    localparam int unsigned DG_MECH      = 25;
    localparam int unsigned DG_MOTOR_T   = 26;
    localparam int unsigned DG_ELEC_T    = 27;
    localparam int unsigned DG_CHECKSUM  = 28;
    localparam int unsigned DG_MEAS      = 29;
    localparam int unsigned DG_INIT      = 30;
    localparam int unsigned DG_CAL       = 31;

    // unit codes of the slot outputs
    localparam logic [7:0] UNIT_PERCENT = 8'h00;
    localparam logic [7:0] UNIT_METER   = 8'h01;
    localparam logic [31:0] UNITS_RESET = 32'h0000_0100;

    typedef struct packed {
        logic [31:0] value;
        logic        valid;
        logic        lossOfEcho;
        logic        failsafeExpired;
        logic        configError;
        logic        badConfig;
        logic        aiOutOfService;
        logic        hiAlarm;
        logic        hiWarn;
        logic        loAlarm;
        logic        loWarn;
    } slot_in_type;

    typedef struct packed {
        logic zeroError;
        logic powerFail;
        logic configInvalid;
        logic warmStart;
        logic coldStart;
        logic electronics;
        logic mechanical;
        logic motorTemp;
        logic electronicsTemp;
        logic checksum;
        logic measurement;
        logic initFail;
        logic calibration;
    } fault_type;

    typedef struct packed {
        logic [7:0] data;
        logic       valid;
        logic       last;
    } byte_out_type;

endpackage

// file: rtl/fieldbus_cyclic_status_encoder.sv
/*
 * cyclic input image framer for a four-slot level instrument: station
 * address, per-slot status byte encoding, slot records, fault flag word.
 * assumes measurement logic on mclk supplies per-slot conditions and that
 * the bus side pulses scanStart once per scan and drains bytes via txReady.
 */
// Function
// - station address 0..126, default 126, local or network
// - new address active only after power-up
// - measured values every scan, configuration only on request
// - slots fixed: level, distance, space, volume
// - empty slot takes block out, sends nothing
// - normal and short module forms behave alike
// - record is float four bytes, then status
// - default units percent, distance in meters
// - empty slots shift later record offsets
// - good 0x80, start-up 0x4C until valid
// - echo loss 0x44, failsafe expiry 0x10
// - config error 0x04, bad config 0xC4
// - out of service 0x1E acyclic, AI 0xDE
// - simulation mode status 0x60
// - high alarm 0x8E, high warning 0x8A
// - low alarm 0x8D, low warning 0x89
// - fault word electronics and mechanical failure bits
// - fault word motor and electronics temperature bits
module fieldbus_cyclic_status_encoder #(
    parameter int unsigned SLOTS = 4
) (
    input  wire logic                                   mclk,
    input  wire logic                                   reset,
    input  wire logic [fieldbus_status_pkg::ADDR_W-1:0] address,
    input  wire logic                                   read,
    input  wire logic                                   write,
    input  wire logic [31:0]                            writedata,
    output logic      [31:0]                            readdata,
    output logic                                        waitrequest,
    input  wire fieldbus_status_pkg::slot_in_type [SLOTS-1:0] slotIn,
    input  wire fieldbus_status_pkg::fault_type             faults,
    input  wire logic                                   stationAddressSettingLoad,
    input  wire logic [6:0]                             stationAddressSetting,
    input  wire logic                                   netAddrLoad,
    input  wire logic [6:0]                             netAddr,
    input  wire logic                                   powerUp,
    input  wire logic                                   scanStart,
    input  wire logic                                   txReady,
    output fieldbus_status_pkg::byte_out_type           txOut,
    output logic                                        scanBusy,
    output logic      [6:0]                             stationAddr,
    output logic      [31:0]                            diagWord
);

    if (SLOTS != fieldbus_status_pkg::SLOT_COUNT)
    begin : g_bad_slots
        $error("slot count must be four");
    end

    typedef enum logic [0:0] {IDLE, SEND} tx_state_type;

    // ---------------- register bus ----------------
    logic        ack;
    logic [6:0]  pendingAddr;
    logic [7:0]  slotCfg;
    logic [3:0]  simEn;
    logic [31:0] simValue;
    logic [31:0] units;

    wire busReq   = (read | write) & ~ack;
    wire wrTaken  = write & ack;
    wire selAddr  = (address == fieldbus_status_pkg::REG_ADDR);
    wire selCfg   = (address == fieldbus_status_pkg::REG_SLOTCFG);
    wire selSim   = (address == fieldbus_status_pkg::REG_SIM);
    wire selSimV  = (address == fieldbus_status_pkg::REG_SIMVAL);
    wire selStat  = (address == fieldbus_status_pkg::REG_STATUS);
    wire selOff   = (address == fieldbus_status_pkg::REG_OFFSET);
    wire selDiag  = (address == fieldbus_status_pkg::REG_DIAG);
    wire selUnits = (address == fieldbus_status_pkg::REG_UNITS);
    wire busAddrOk = (writedata[6:0] <= fieldbus_status_pkg::STATION_MAX);
    wire localOk   = (stationAddressSetting <= fieldbus_status_pkg::STATION_MAX);
    wire netOk     = (netAddr <= fieldbus_status_pkg::STATION_MAX);

    assign waitrequest = (read | write) & ~ack;

    always_ff @(posedge mclk)
    begin
        if (reset)
            ack <= 1'b0;
        else
            ack <= busReq;
    end

    logic [6:0] next_pendingAddr;
    always_comb
    begin
        next_pendingAddr = pendingAddr;
        if (stationAddressSettingLoad && localOk)
            next_pendingAddr = stationAddressSetting;
        if (netAddrLoad && netOk)
            next_pendingAddr = netAddr;
        if (wrTaken && selAddr && busAddrOk)
            next_pendingAddr = writedata[6:0];
    end

    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            pendingAddr <= fieldbus_status_pkg::STATION_RESET;
            stationAddr <= fieldbus_status_pkg::STATION_RESET;
        end
        else
        begin
            pendingAddr <= next_pendingAddr;
            if (powerUp)
                stationAddr <= pendingAddr;
        end
    end

    // writes that steer slot forms and simulation
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            slotCfg  <= fieldbus_status_pkg::SLOTCFG_RESET;
            simEn    <= 4'h0;
            simValue <= 32'h0000_0000;
        end
        else if (wrTaken)
        begin
            if (selCfg)
                slotCfg <= writedata[7:0];
            if (selSim)
                simEn <= writedata[3:0];
            if (selSimV)
                simValue <= writedata;
        end
    end

    // default units, level/space/volume percent, distance meters
    assign units = fieldbus_status_pkg::UNITS_RESET;

    // ---------------- per-slot status ----------------
    logic [SLOTS-1:0] firstValid;
    logic [SLOTS-1:0] slotUsed;
    logic [7:0]       status     [SLOTS];
    logic [7:0]       offset     [SLOTS];
    logic [31:0]      slotValue  [SLOTS];
    logic [39:0]      record     [SLOTS];

    for (genvar i = 0; i < SLOTS; i++)
    begin : g_slot
        wire [1:0] form = slotCfg[2*i +: 2];
        wire       sim  = simEn[i];
        // both forms select the same block
        assign slotUsed[i] = (form == fieldbus_status_pkg::FORM_NORMAL) |
                             (form == fieldbus_status_pkg::FORM_SHORT);
        assign slotValue[i] = sim ? simValue : slotIn[i].value;

        always_ff @(posedge mclk)
        begin
            if (reset)
                firstValid[i] <= 1'b0;
            else if (slotIn[i].valid)
                firstValid[i] <= 1'b1;
        end

        always_comb
        begin
            // empty slot is out of service
            if (!slotUsed[i])
                status[i] = fieldbus_status_pkg::ST_FB_OOS;
            else if (slotIn[i].aiOutOfService)
                status[i] = fieldbus_status_pkg::ST_AI_OOS;
            else if (slotIn[i].badConfig)
                status[i] = fieldbus_status_pkg::ST_BAD_CFG;
            else if (slotIn[i].configError)
                status[i] = fieldbus_status_pkg::ST_CFG_ERR;
            else if (sim)
                status[i] = fieldbus_status_pkg::ST_SIM;
            else if (!firstValid[i])
                status[i] = fieldbus_status_pkg::ST_INIT;
            else if (slotIn[i].failsafeExpired)
                status[i] = fieldbus_status_pkg::ST_FAILSAFE;
            else if (slotIn[i].lossOfEcho)
                status[i] = fieldbus_status_pkg::ST_LAST_USE;
            else if (slotIn[i].hiAlarm)
                status[i] = fieldbus_status_pkg::ST_HI_ALARM;
            else if (slotIn[i].loAlarm)
                status[i] = fieldbus_status_pkg::ST_LO_ALARM;
            else if (slotIn[i].hiWarn)
                status[i] = fieldbus_status_pkg::ST_HI_WARN;
            else if (slotIn[i].loWarn)
                status[i] = fieldbus_status_pkg::ST_LO_WARN;
            else
                status[i] = fieldbus_status_pkg::ST_GOOD;
        end

        assign record[i] = {slotValue[i], status[i]};
    end

    always_comb
    begin
        logic [7:0] run;
        run = 8'h00;
        for (int j = 0; j < SLOTS; j++)
        begin
            offset[j] = slotUsed[j] ? run : fieldbus_status_pkg::OFFSET_NONE;
            if (slotUsed[j])
                run = run + 8'(fieldbus_status_pkg::REC_BYTES);
        end
    end

    // ---------------- fault flag word ----------------
    logic [31:0] next_diag;
    always_comb
    begin
        next_diag = 32'h0000_0000;
        next_diag[fieldbus_status_pkg::DG_ZERO]     = faults.zeroError;
        next_diag[fieldbus_status_pkg::DG_POWER]    = faults.powerFail;
        next_diag[fieldbus_status_pkg::DG_CFG]      = faults.configInvalid;
        next_diag[fieldbus_status_pkg::DG_WARM]     = faults.warmStart;
        next_diag[fieldbus_status_pkg::DG_COLD]     = faults.coldStart;
        next_diag[fieldbus_status_pkg::DG_ELEC]     = faults.electronics;
        next_diag[fieldbus_status_pkg::DG_MECH]     = faults.mechanical;
        next_diag[fieldbus_status_pkg::DG_MOTOR_T]  = faults.motorTemp;
        next_diag[fieldbus_status_pkg::DG_ELEC_T]   = faults.electronicsTemp;
        next_diag[fieldbus_status_pkg::DG_CHECKSUM] = faults.checksum;
        next_diag[fieldbus_status_pkg::DG_MEAS]     = faults.measurement;
        next_diag[fieldbus_status_pkg::DG_INIT]     = faults.initFail;
        next_diag[fieldbus_status_pkg::DG_CAL]      = faults.calibration;
    end

    always_ff @(posedge mclk)
    begin
        if (reset)
            diagWord <= 32'h0000_0000;
        else
            diagWord <= next_diag;
    end

    // ---------------- read mux ----------------
    // configuration and status reach software only on request
    wire [31:0] rdAddr   = {17'h0_0000, stationAddr, 1'b0, pendingAddr};
    wire [31:0] rdStat   = {status[3], status[2], status[1], status[0]};
    wire [31:0] rdOff    = {offset[3], offset[2], offset[1], offset[0]};
    wire [31:0] rdMux    =
        selAddr  ? rdAddr :
        selCfg   ? {24'h00_0000, slotCfg} :
        selSim   ? {28'h000_0000, simEn} :
        selSimV  ? simValue :
        selStat  ? rdStat :
        selOff   ? rdOff :
        selDiag  ? diagWord :
        selUnits ? units : 32'h0000_0000;

    always_ff @(posedge mclk)
    begin
        if (reset)
            readdata <= 32'h0000_0000;
        else if (read && busReq)
            readdata <= rdMux;
    end

    // ---------------- cyclic image stream ----------------
    tx_state_type     state;
    logic [39:0]      snap [SLOTS];
    logic [SLOTS-1:0] snapUsed;
    logic [1:0]       slotPtr;
    logic [2:0]       bytePtr;

    // first used slot after the current one, or none
    function automatic logic [2:0] nextUsed(input logic [SLOTS-1:0] used, input logic [2:0] from);
        logic [2:0] r;
        r = 3'h4;
        for (int k = SLOTS - 1; k >= 0; k--)
        begin
            if (used[k] && (3'(k) >= from))
                r = 3'(k);
        end
        return r;
    endfunction

    wire [2:0] firstSlot = nextUsed(slotUsed, 3'h0);
    wire [2:0] nextSlot  = nextUsed(snapUsed, {1'b0, slotPtr} + 3'h1);
    wire       recEnd    = (bytePtr == 3'(fieldbus_status_pkg::REC_BYTES - 1));
    wire       lastByte  = recEnd && nextSlot[2];
    wire [39:0] curRec   = snap[slotPtr];
    wire       beat      = txOut.valid & txReady;

    assign scanBusy = (state == SEND);

    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            state    <= IDLE;
            snapUsed <= '0;
            slotPtr  <= 2'h0;
            bytePtr  <= 3'h0;
        end
        else
        begin
            case (state)
                IDLE:
                begin
                    // whole image frozen at scan start
                    if (scanStart && !firstSlot[2])
                    begin
                        for (int s = 0; s < SLOTS; s++)
                            snap[s] <= record[s];
                        snapUsed <= slotUsed;
                        slotPtr  <= firstSlot[1:0];
                        bytePtr  <= 3'h0;
                        state    <= SEND;
                    end
                end
                SEND:
                begin
                    if (beat)
                    begin
                        if (lastByte)
                            state <= IDLE;
                        else if (recEnd)
                        begin
                            slotPtr <= nextSlot[1:0];
                            bytePtr <= 3'h0;
                        end
                        else
                            bytePtr <= bytePtr + 3'h1;
                    end
                end
                default:
                    state <= IDLE;
            endcase
        end
    end

    // byte out: value msb first, status byte last
    always_comb
    begin
        txOut.valid = (state == SEND);
        txOut.last  = (state == SEND) && lastByte;
        case (bytePtr)
            3'h0:    txOut.data = curRec[39:32];
            3'h1:    txOut.data = curRec[31:24];
            3'h2:    txOut.data = curRec[23:16];
            3'h3:    txOut.data = curRec[15:8];
            default: txOut.data = curRec[7:0];
        endcase
    end

endmodule

// file: dv/fieldbus_cyclic_status_encoder_properties.sv
/*
 * assertion checker for the cyclic status encoder ports.
 * assumes one clock domain with a synchronous active-high reset.
 */
module fieldbus_cyclic_status_encoder_properties #(
    parameter int unsigned SLOTS = 4
) (
    input wire logic                              mclk,
    input wire logic                              reset,
    input wire logic                              read,
    input wire logic                              write,
    input wire logic                              waitrequest,
    input wire fieldbus_status_pkg::fault_type    faults,
    input wire logic                              powerUp,
    input wire logic                              scanStart,
    input wire logic                              txReady,
    input wire fieldbus_status_pkg::byte_out_type txOut,
    input wire logic [6:0]                        stationAddr,
    input wire logic [31:0]                       diagWord
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [4:0]  beats;
    wire  [31:0] diagExp = {faults.calibration, faults.initFail, faults.measurement, faults.checksum,
        faults.electronicsTemp, faults.motorTemp, faults.mechanical, faults.electronics, 3'h0,
        faults.coldStart, faults.warmStart, faults.configInvalid, faults.powerFail, faults.zeroError, 16'h0};
    default clocking @(posedge mclk); endclocking
    default disable iff (reset);
    // accepted beats of the running image
    always_ff @(posedge mclk)
        if (reset || (txOut.valid && txReady && txOut.last))
            beats <= 5'h0;
        else if (txOut.valid && txReady)
            beats <= beats + 5'h1;
    sequence accessWait;
        waitrequest ##1 !waitrequest;
    endsequence
    sequence byteHeld;
        txOut.valid && $stable(txOut.data) && $stable(txOut.last);
    endsequence
    AST_BUS_ONE_WAIT: // one wait state
        assert property ($rose(read || write) |-> accessWait) else $error("bus wait state wrong");
    AST_ADDR_HELD: // address kept
        assert property (!powerUp |=> $stable(stationAddr)) else $error("address moved without power-up");
    AST_DIAG_FAIL: // failure bits
        assert property (1'b1 |=> ((diagWord ^ $past(diagExp)) & 32'h0300_0000) == 32'h0)
            else $error("failure bits of fault word wrong");
    AST_DIAG_TEMP: // temperature bits
        assert property (1'b1 |=> ((diagWord ^ $past(diagExp)) & 32'h0C00_0000) == 32'h0)
            else $error("temperature bits of fault word wrong");
    AST_DIAG_LOW: // low flag bits
        assert property (1'b1 |=> ((diagWord ^ $past(diagExp)) & 32'h00FF_FFFF) == 32'h0)
            else $error("low bits of fault word wrong");
    AST_DIAG_TOP: // top nibble
        assert property (1'b1 |=> ((diagWord ^ $past(diagExp)) & 32'hF000_0000) == 32'h0)
            else $error("top bits of fault word wrong");
    AST_SCAN_CAUSE: // scan starts image
        assert property ($rose(txOut.valid) |-> $past(scanStart)) else $error("image sent without scan");
    AST_BYTE_HELD: // byte held
        assert property (txOut.valid && !txReady |=> byteHeld) else $error("byte changed while stalled");
    AST_LAST_ENDS: // image ends
        assert property (txOut.valid && txReady && txOut.last |=> !txOut.valid) else $error("stream ran on");
    AST_WHOLE_RECORDS: // whole records
        assert property (txOut.valid && txReady && txOut.last |-> beats inside {5'h4, 5'h9, 5'hE, 5'h13})
            else $error("image not whole records");
endmodule

bind fieldbus_cyclic_status_encoder fieldbus_cyclic_status_encoder_properties #(.SLOTS(SLOTS)) props (
    .mclk(mclk), .reset(reset), .read(read), .write(write), .waitrequest(waitrequest), .faults(faults),
    .powerUp(powerUp), .scanStart(scanStart), .txReady(txReady), .txOut(txOut),
    .stationAddr(stationAddr), .diagWord(diagWord)
);

// file: dv/cyclic_master_model.sv
/*
 * cyclic master stand-in: drains each image with random stalls.
 * assumes the bench seeds the generator and reads rxq itself.
 */
module cyclic_master_model (
    input  wire logic                              mclk,
    input  wire logic                              reset,
    input  wire fieldbus_status_pkg::byte_out_type txOut,
    input  wire logic [6:0]                        stallPct,
    output logic                                   txReady
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] part[$];
    logic [7:0] rxq[$];
    always @(posedge mclk)
    begin
        if (reset)
        begin
            part.delete();
            txReady <= 1'b0;
        end
        else
        begin
            if (txOut.valid && txReady)
                part.push_back(txOut.data);
            if (part.size() == 5)
            begin
                rxq = {rxq, part};
                part.delete();
            end
            txReady <= ($urandom_range(99) >= stallPct);
        end
    end
endmodule

// file: dv/fieldbus_cyclic_status_encoder_tb.sv
/*
 * self-checking bench for the cyclic status encoder.
 * assumes the bound checker and the master model beside the design.
 */
module fieldbus_cyclic_status_encoder_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int unsigned SLOTS = 4;
    logic        mclk = 1'b0;
    logic        reset = 1'b1;
    logic [4:0]  address = 5'h0;
    logic        read = 1'b0;
    logic        write = 1'b0;
    logic [31:0] writedata = 32'h0;
    logic [31:0] readdata;
    logic        waitrequest;
    logic        stationAddressSettingLoad = 1'b0;
    logic [6:0]  stationAddressSetting = 7'h0;
    logic        netAddrLoad = 1'b0;
    logic [6:0]  netAddr = 7'h0;
    logic        powerUp = 1'b0;
    logic        scanStart = 1'b0;
    logic        txReady;
    logic        scanBusy;
    logic [6:0]  stationAddr;
    logic [31:0] diagWord;
    logic [6:0]  stallPct = 7'h0;
    logic [31:0] q, v, dv, simv, stat, off;
    logic [6:0]  act = 7'h7E;
    logic [7:0]  cfg;
    logic [3:0]  sim;
    logic [10:0] c;
    int          fails = 0;
    int          nTests = 0;
    int          seed, i, pos;
    logic [7:0]  expQ[$];
    logic [7:0]  codes[11] = '{8'hDE, 8'hC4, 8'h04, 8'h60, 8'h10, 8'h44, 8'h8E, 8'h8D, 8'h8A, 8'h89, 8'h80};
    fieldbus_status_pkg::slot_in_type [SLOTS-1:0] slotIn = '0;
    fieldbus_status_pkg::fault_type               faults = '0;
    fieldbus_status_pkg::byte_out_type            txOut;

    fieldbus_cyclic_status_encoder #(.SLOTS(SLOTS)) dut (
        .mclk, .reset, .address, .read, .write, .writedata, .readdata, .waitrequest, .slotIn, .faults,
        .stationAddressSettingLoad, .stationAddressSetting, .netAddrLoad, .netAddr, .powerUp,
        .scanStart, .txReady, .txOut, .scanBusy, .stationAddr, .diagWord
    );
    cyclic_master_model partner (.mclk, .reset, .txOut, .stallPct, .txReady);

    always #2.5 mclk = ~mclk;

    task automatic printVerdict();
        $display("comparisons %0d, mismatches %0d", nTests, fails);
        if (fails == 0 && nTests > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        nTests++;
        if (got !== exp)
        begin
            fails++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
        address   <= a;
        writedata <= d;
        write     <= wr;
        read      <= !wr;
        do @(posedge mclk); while (waitrequest !== 1'b0);
        q = readdata;
        read  <= 1'b0;
        write <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic rdChk(input logic [4:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(q, exp);
    endtask
    task automatic setAddr(input int src, input logic [6:0] a);
        netAddr <= a;
        stationAddressSetting <= a;
        netAddrLoad <= (src == 1);
        stationAddressSettingLoad <= (src == 2);
        @(posedge mclk);
        netAddrLoad <= 1'b0;
        stationAddressSettingLoad <= 1'b0;
        if (src == 0)
            bus(1'b1, 5'h00, {25'h0, a});
    endtask
    function automatic logic [31:0] diagExp(input fieldbus_status_pkg::fault_type f);
        diagExp = {f.calibration, f.initFail, f.measurement, f.checksum, f.electronicsTemp, f.motorTemp,
                   f.mechanical, f.electronics, 3'h0, f.coldStart, f.warmStart, f.configInvalid,
                   f.powerFail, f.zeroError, 16'h0};
    endfunction

    initial
    begin
        repeat (20000) @(posedge mclk);
        fails++;
        printVerdict();
    end

    initial
    begin
        seed = $urandom(41624);
        repeat (12) @(posedge mclk);
        reset <= 1'b0;
        rdChk(5'h00, 32'h0000_7E7E);
        rdChk(5'h04, 32'h0000_0055);
        rdChk(5'h1C, 32'h0000_0100);
        rdChk(5'h10, 32'h4C4C_4C4C);
        rdChk(5'h02, 32'h0000_0000);
        for (int s = 0; s < SLOTS; s++)
            slotIn[s] <= {32'h0, 1'b1, 9'h0};
        repeat (3) @(posedge mclk);
        rdChk(5'h10, 32'h8080_8080);
        for (int src = 0; src < 3; src++)
        begin
            v = (src == 0) ? 32'h0 : $urandom_range(126);
            setAddr(src, 7'h7F);
            rdChk(5'h00, {17'h0, act, 1'b0, act});
            setAddr(src, v[6:0]);
            rdChk(5'h00, {17'h0, act, 1'b0, v[6:0]});
            chk({25'h0, stationAddr}, {25'h0, act});
            powerUp <= 1'b1;
            @(posedge mclk);
            powerUp <= 1'b0;
            @(posedge mclk);
            chk({25'h0, stationAddr}, v);
            act = v[6:0];
        end
        repeat (20)
        begin
            faults <= 13'($urandom);
            repeat (2) @(posedge mclk);
            chk(diagWord, diagExp(faults));
            rdChk(5'h18, diagExp(faults));
        end
        for (int it = 0; it < 22; it++)
        begin
            expQ.delete();
            cfg = (it == 5) ? 8'h00 : 8'($urandom);
            simv = $urandom;
            pos = 0;
            for (int s = 0; s < SLOTS; s++)
            begin
                i = (it + s) % 11;
                c = (11'h1 << (10 - i)) | (11'($urandom) & ((11'h1 << (10 - i)) - 11'h1));
                v = $urandom;
                sim[s] = c[7];
                slotIn[s] <= {v, 1'b1, c[5], c[6], c[8], c[9], c[10], c[4], c[2], c[3], c[1]};
                stat[8*s +: 8] = (cfg[2*s +: 2] inside {2'h1, 2'h2}) ? codes[i] : 8'h1E;
                off[8*s +: 8] = (cfg[2*s +: 2] inside {2'h1, 2'h2}) ? 8'(pos) : 8'hFF;
                dv = c[7] ? simv : v;
                if (cfg[2*s +: 2] inside {2'h1, 2'h2})
                begin
                    expQ = {expQ, dv[31:24], dv[23:16], dv[15:8], dv[7:0], codes[i]};
                    pos += 5;
                end
            end
            bus(1'b1, 5'h04, {24'h0, cfg});
            bus(1'b1, 5'h08, {28'h0, sim});
            bus(1'b1, 5'h0C, simv);
            rdChk(5'h10, stat);
            rdChk(5'h14, off);
            stallPct <= 7'(it * 4);
            scanStart <= 1'b1;
            @(posedge mclk);
            scanStart <= 1'b0;
            repeat (2) @(posedge mclk);
            chk({31'h0, scanBusy}, {31'h0, expQ.size() != 0});
            // a second start while busy must be ignored
            scanStart <= 1'b1;
            @(posedge mclk);
            scanStart <= 1'b0;
            do @(negedge mclk); while (scanBusy !== 1'b0);
            repeat (3) @(posedge mclk);
            chk(32'(partner.rxq.size()), 32'(expQ.size()));
            foreach (expQ[k])
                chk({24'h0, partner.rxq[k]}, {24'h0, expQ[k]});
            partner.rxq.delete();
        end
        printVerdict();
    end
endmodule
